//--- src/gms_regs.v
// Purpose: Gigabit master/slave control, status, extended_ability_status and page-received flag.
// Assumes: The management engine gives a register index with one-cycle read and write
//          strobes; the PHY core gives same-clock status levels and event pulses.
// Notes: Straps are pins and pass a synchroniser; they are captured after reset and again on each soft reset.
`timescale 1ns/1ps
`default_nettype none
`include "gms_map.vh"
module gms_regs (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_soft_rst,
  input wire i_logic_rst,
  input wire [4:0] i_reg_idx,
  input wire i_rd_stb,
  input wire i_wr_stb,
  input wire [15:0] i_wr_data,
  output reg [15:0] o_rd_data,
  output wire o_rd_hit,
  input wire [4:0] i_strap_ctrl,
  input wire i_ms_fault,
  input wire i_auto_master,
  input wire i_local_rx_ok,
  input wire i_remote_rx_ok,
  input wire i_partner_gig_full_duplex,
  input wire i_partner_gig_half_duplex,
  input wire i_page_rx_evt,
  input wire i_idle_err,
  output reg [2:0] o_test_mode,
  output reg o_manual_cfg_en,
  output reg o_manual_master,
  output reg o_multiport,
  output reg o_adv_gig_fd,
  output reg o_adv_gig_hd,
  output reg o_resolved_master,
  output wire o_idle_cnt_sat,
  output reg o_idle_ovf_evt,
  output wire o_page_rx
);
  // Strap capture states: two edges fill the synchroniser, the third loads control.
  localparam ST_WAIT = 4'b0001;
  localparam ST_SETTLE = 4'b0010;
  localparam ST_LOAD = 4'b0100;
  localparam ST_RUN = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [15:0] ctrl_q;
  reg fault_q;
  reg page_q;
  reg sat_q;
  reg master_q;
  reg fault_d;
  reg page_d;
  reg [15:0] rd_d;
  reg [2:0] tm_d;
  wire [4:0] strap_s;
  wire [7:0] idle_cnt;
  wire idle_sat;
  wire rd_ctrl;
  wire rd_stat;
  wire rd_exp;
  wire wr_ctrl;
  wire cnt_clr;
  wire [15:0] stat_word;
  wire [15:0] exp_word;
  wire role_master;

  function sel;
    input [4:0] idx;
    input [4:0] want;
    input stb;
    begin
      sel = stb && (idx == want);
    end
  endfunction

  gms_sync #(
    .W(5)
  ) u_strap_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_async(i_strap_ctrl),
    .o_sync(strap_s)
  );

  assign rd_ctrl = sel(i_reg_idx, `GMS_IDX_CONTROL, i_rd_stb);
  assign rd_stat = sel(i_reg_idx, `GMS_IDX_STATUS, i_rd_stb);
  assign rd_exp = sel(i_reg_idx, `GMS_IDX_EXPANSION, i_rd_stb);
  assign wr_ctrl = sel(i_reg_idx, `GMS_IDX_CONTROL, i_wr_stb);
  assign cnt_clr = rd_stat || i_soft_rst || i_logic_rst;

  gms_idle_cnt u_idle_cnt (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_clr(cnt_clr),
    .i_err(i_idle_err),
    .o_cnt(idle_cnt),
    .o_sat(idle_sat)
  );

  // The straps settle through the synchroniser before they are loaded.
  always @*
  begin
    case (st_q)
      ST_WAIT: st_d = ST_SETTLE;
      ST_SETTLE: st_d = ST_LOAD;
      ST_LOAD: st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_WAIT;
    endcase
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= ST_WAIT;
      ctrl_q <= 16'h0000;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == ST_LOAD || i_soft_rst)
        ctrl_q <= {`GMS_TM_RESET, strap_s, 8'h00};
      else if (wr_ctrl)
        ctrl_q <= i_wr_data & `GMS_CTRL_WMASK;
    end
  end

  // Role resolution: manual value when enabled, else the automatic i_auto_master input.
  assign role_master = ctrl_q[`GMS_MAN_EN_BIT] ? ctrl_q[`GMS_MAN_VAL_BIT]
                                                : i_auto_master;

  // A flag event in the cycle of its clearing read wins, so no event is lost.
  always @*
  begin
    fault_d = fault_q;
    if (i_ms_fault)
      fault_d = 1'b1;
    else if (rd_stat)
      fault_d = 1'b0;
  end

  always @*
  begin
    page_d = page_q;
    if (i_page_rx_evt)
      page_d = 1'b1;
    else if (rd_exp)
      page_d = 1'b0;
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fault_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_d;
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      page_q <= 1'b0;
    end
    else
    begin
      page_q <= page_d;
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      master_q <= 1'b0;
    end
    else
    begin
      master_q <= role_master;
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sat_q <= 1'b0;
    end
    else
    begin
      sat_q <= idle_sat;
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_idle_ovf_evt <= 1'b0;
    end
    else
    begin
      o_idle_ovf_evt <= idle_sat && !sat_q;
    end
  end

  assign stat_word = {fault_q, master_q, i_local_rx_ok, i_remote_rx_ok,
                      i_partner_gig_full_duplex, i_partner_gig_half_duplex,
                      2'b00, idle_cnt};
  assign exp_word = {14'h0000, page_q, 1'b0};
  assign o_rd_hit = (i_reg_idx == `GMS_IDX_CONTROL) || (i_reg_idx == `GMS_IDX_STATUS) ||
                    (i_reg_idx == `GMS_IDX_EXT_STATUS) || (i_reg_idx == `GMS_IDX_EXPANSION);
  assign o_idle_cnt_sat = idle_sat;
  assign o_page_rx = page_q;

  // Read data is picked here and registered below, so it stands until the next read.
  always @*
  begin
    rd_d = o_rd_data;
    if (i_rd_stb)
    begin
      case (i_reg_idx)
        `GMS_IDX_CONTROL: rd_d = ctrl_q;
        `GMS_IDX_STATUS: rd_d = stat_word;
        `GMS_IDX_EXT_STATUS: rd_d = `GMS_EXT_STATUS_VAL;
        `GMS_IDX_EXPANSION: rd_d = exp_word;
        default: rd_d = 16'h0000;
      endcase
    end
  end

  // Reserved test codes fall back to normal transmission.
  always @*
  begin
    tm_d = ctrl_q[`GMS_TM_HI:`GMS_TM_LO];
    if (tm_d > `GMS_TM_DISTORTION)
      tm_d = `GMS_TM_NORMAL;
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rd_data <= 16'h0000;
    end
    else
    begin
      o_rd_data <= rd_d;
    end
  end

  // Control outputs follow the control register one cycle later; o_resolved_master follows two cycles later, through master_q.
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_test_mode <= `GMS_TM_RESET;
    end
    else
    begin
      o_test_mode <= tm_d;
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_manual_cfg_en <= 1'b0;
    end
    else
    begin
      o_manual_cfg_en <= ctrl_q[`GMS_MAN_EN_BIT];
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_manual_master <= 1'b0;
    end
    else
    begin
      o_manual_master <= ctrl_q[`GMS_MAN_VAL_BIT] & ctrl_q[`GMS_MAN_EN_BIT];
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_multiport <= 1'b0;
    end
    else
    begin
      o_multiport <= ctrl_q[`GMS_PORT_TYPE_BIT] & ~ctrl_q[`GMS_MAN_EN_BIT];
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_adv_gig_fd <= 1'b0;
    end
    else
    begin
      o_adv_gig_fd <= ctrl_q[`GMS_ADV_FD_BIT];
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_adv_gig_hd <= 1'b0;
    end
    else
    begin
      o_adv_gig_hd <= ctrl_q[`GMS_ADV_HD_BIT];
    end
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_resolved_master <= 1'b0;
    end
    else
    begin
      o_resolved_master <= master_q;
    end
  end
endmodule // gms_regs
`default_nettype wire

//--- src/gms_map.vh
// Purpose: Register indices, field positions, reset values and limits for the gigabit
//          master/slave register group.
// Assumes: 16-bit management registers addressed by a 5-bit register index.
// Notes: Included by gms_regs and gms_idle_cnt; gms_sync does not include it.
`ifndef GMS_MAP_VH
`define GMS_MAP_VH
`define GMS_IDX_EXPANSION 5'h06
`define GMS_IDX_CONTROL 5'h09
`define GMS_IDX_STATUS 5'h0a
`define GMS_IDX_EXT_STATUS 5'h0f
`define GMS_TM_HI 15
`define GMS_TM_LO 13
`define GMS_MAN_EN_BIT 12
`define GMS_MAN_VAL_BIT 11
`define GMS_PORT_TYPE_BIT 10
`define GMS_ADV_FD_BIT 9
`define GMS_ADV_HD_BIT 8
`define GMS_TM_NORMAL 3'h0
`define GMS_TM_WAVEFORM 3'h1
`define GMS_TM_JIT_MASTER 3'h2
`define GMS_TM_JIT_SLAVE 3'h3
`define GMS_TM_DISTORTION 3'h4
`define GMS_TM_RESET 3'h0
`define GMS_CTRL_WMASK 16'hff00
`define GMS_EXT_STATUS_VAL 16'h3000
`define GMS_IDLE_CNT_MAX 8'hff
`define GMS_PAGE_RX_BIT 1
`endif

//--- src/gms_sync.v
// Purpose: Two-flop synchroniser for a bus of pin-level inputs.
// Assumes: Inputs are slow levels from outside the clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module gms_sync #(
  parameter W = 1
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // gms_sync
`default_nettype wire

//--- src/gms_idle_cnt.v
// Purpose: Saturating idle error counter with clear on read.
// Assumes: i_err is a one-cycle pulse on the device clock.
// Notes: A clear in the same cycle as an error leaves a count of one, so no error is lost.
`timescale 1ns/1ps
`default_nettype none
`include "gms_map.vh"
module gms_idle_cnt (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_clr,
  input wire i_err,
  output wire [7:0] o_cnt,
  output wire o_sat
);
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  always @*
  begin
    cnt_d = cnt_q;
    if (i_clr)
      cnt_d = i_err ? 8'h01 : 8'h00;
    else if (i_err && (cnt_q != `GMS_IDLE_CNT_MAX))
      cnt_d = cnt_q + 8'h01;
  end
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end
  assign o_cnt = cnt_q;
  assign o_sat = (cnt_q == `GMS_IDLE_CNT_MAX);
endmodule // gms_idle_cnt
`default_nettype wire

//--- dv/gms_regs_props.sv
// Purpose: Port assertions for the gigabit master/slave registers.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module gms_regs_props (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_soft_rst,
  input wire logic i_logic_rst,
  input wire logic [4:0] i_reg_idx,
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire logic [15:0] i_wr_data,
  input wire logic [15:0] o_rd_data,
  input wire logic i_page_rx_evt,
  input wire logic i_idle_err,
  input wire logic [2:0] o_test_mode,
  input wire logic o_manual_cfg_en,
  input wire logic o_manual_master,
  input wire logic o_multiport,
  input wire logic o_adv_gig_fd,
  input wire logic o_idle_cnt_sat,
  input wire logic o_page_rx
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire rd_st;
  assign rd_st = i_rd_stb && i_reg_idx == 5'h0a;
  AST_TM_RANGE: assert property (o_test_mode <= 3'h4)
    else $error("test mode out of range");
  AST_CTRL_WR: assert property (i_wr_stb && i_reg_idx == 5'h09 && !i_soft_rst |-> ##2
    o_multiport == ($past(i_wr_data[10], 2) & !$past(i_wr_data[12], 2)) &&
    o_adv_gig_fd == $past(i_wr_data[9], 2)) else $error("control outputs wrong");
  AST_MAN_GATE: assert property (i_wr_stb && i_reg_idx == 5'h09 && !i_soft_rst |-> ##2
    o_manual_cfg_en == $past(i_wr_data[12], 2) &&
    o_manual_master == ($past(i_wr_data[11], 2) & $past(i_wr_data[12], 2)))
    else $error("manual outputs wrong");
  AST_EXT_RD: assert property (i_rd_stb && i_reg_idx == 5'h0f |=> o_rd_data == 16'h3000)
    else $error("extended_ability_status wrong");
  AST_CTRL_RSV: assert property (i_rd_stb && i_reg_idx == 5'h09 |=> o_rd_data[7:0] == 8'h00)
    else $error("control low byte not zero");
  AST_CNT_CLR: assert property (rd_st && !i_idle_err ##1 !i_idle_err ##1 rd_st |=>
    o_rd_data[7:0] == 8'h00) else $error("count not cleared by read");
  AST_SAT_HOLD: assert property (o_idle_cnt_sat && !i_rd_stb && !i_soft_rst && !i_logic_rst
    |=> o_idle_cnt_sat) else $error("saturation lost");
  AST_PAGE_SET: assert property (i_page_rx_evt |=> o_page_rx)
    else $error("page flag not set");
  AST_PAGE_CLR: assert property (i_rd_stb && i_reg_idx == 5'h06 && !i_page_rx_evt |=>
    !o_page_rx) else $error("page flag not cleared by read");
endmodule // gms_regs_props
`default_nettype wire

//--- dv/gms_host.sv
// Purpose: Station management host model for register access.
// Assumes: Read data is valid right after the strobe edge.
// Notes: Write data is inverted once released so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module gms_host (
  input wire logic i_mclk,
  input wire logic [15:0] i_rd_data,
  output logic [4:0] o_idx = 5'h00,
  output logic o_rd = 1'h0,
  output logic o_wr = 1'h0,
  output logic [15:0] o_wd = 16'h0000
);
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    #1;
    o_idx = a;
    o_wd = d;
    o_wr = 1'h1;
    @(posedge i_mclk);
    #1;
    o_wr = 1'h0;
    o_wd = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    #1;
    o_idx = a;
    o_rd = 1'h1;
    @(posedge i_mclk);
    #1;
    o_rd = 1'h0;
    d = i_rd_data;
  endtask
endmodule // gms_host
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the gigabit master/slave registers.
// Assumes: The host model makes every register access.
// Notes: Straps and status levels are random from seed 3.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, srst = 0, lrst = 0, flt = 0, ierr = 0, pge = 0;
  logic am = 0, lok = 0, rok = 0, pfd = 0, phd = 0;
  logic [4:0] strap = 5'h00;
  logic [4:0] idx;
  logic rd, wr, hit, mm, mp, fd, hd, rm, sat, ovf, prx, me;
  logic [15:0] wd, rdd, v, s;
  logic [2:0] tm;
  int err_total = 0, n_compared = 0, novf = 0, i, n;
  always #25 clk = ~clk;
  always @(posedge clk) novf += ovf;
  gms_host i_gms_host (.i_mclk(clk), .i_rd_data(rdd), .o_idx(idx), .o_rd(rd), .o_wr(wr),
    .o_wd(wd));
  gms_regs i_gms_regs (.i_mclk(clk), .i_nrst(nrst), .i_soft_rst(srst), .i_logic_rst(lrst),
    .i_reg_idx(idx), .i_rd_stb(rd), .i_wr_stb(wr), .i_wr_data(wd), .o_rd_data(rdd),
    .o_rd_hit(hit), .i_strap_ctrl(strap), .i_ms_fault(flt), .i_auto_master(am),
    .i_local_rx_ok(lok), .i_remote_rx_ok(rok), .i_partner_gig_full_duplex(pfd),
    .i_partner_gig_half_duplex(phd), .i_page_rx_evt(pge), .i_idle_err(ierr),
    .o_test_mode(tm), .o_manual_cfg_en(me), .o_manual_master(mm), .o_multiport(mp),
    .o_adv_gig_fd(fd), .o_adv_gig_hd(hd), .o_resolved_master(rm), .o_idle_cnt_sat(sat),
    .o_idle_ovf_evt(ovf), .o_page_rx(prx));
  function automatic logic [2:0] exp_tm(input logic [2:0] c);
    return (c > 3'h4) ? 3'h0 : c;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    n_compared++;
    if (seen !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic errp(input int k);
    repeat (k)
    begin
      ierr = 1;
      cyc(1);
      ierr = 0;
      cyc(1);
    end
  endtask
  initial
  begin
    #500000;
    err_total++;
    final_report;
  end
  initial
  begin
    void'($urandom(3));
    strap = 5'($urandom);
    {am, lok, rok, pfd, phd} = 5'($urandom);
    cyc(20);
    nrst = 1;
    cyc(4);
    i_gms_host.rd(5'h09, v);
    chk("ctrl reset", v, {3'h0, strap, 8'h00});
    for (i = 0; i < 8; i++)
    begin
      {am, lok, rok, pfd, phd} = 5'($urandom);
      v = {i[2:0], 13'($urandom)};
      v[11] = v[11] & (i == 0);
      i_gms_host.wr(5'h09, v);
      cyc(4);
      chk("test mode", tm, exp_tm(v[15:13]));
      chk("ctrl out", {me, mm, mp, fd, hd},
        {v[12], v[12] & v[11], ~v[12] & v[10], v[9:8]});
      chk("role", rm, v[12] ? v[11] : am);
      i_gms_host.rd(5'h0a, s);
      chk("status", s[14:8], {v[12] ? v[11] : am, lok, rok, pfd, phd, 2'h0});
    end
    i_gms_host.wr(5'h0f, 16'hffff);
    i_gms_host.rd(5'h0f, v);
    chk("ext", v, 16'h3000);
    chk("hit", hit, 1'h1);
    i_gms_host.rd(5'h03, v);
    chk("unmapped", hit, 1'h0);
    chk("unmapped data", v, 16'h0000);
    flt = 1;
    cyc(1);
    flt = 0;
    i_gms_host.rd(5'h0a, v);
    chk("fault", v[15], 1'h1);
    i_gms_host.rd(5'h0a, v);
    chk("fault clr", v[15], 1'h0);
    n = $urandom_range(40, 1);
    errp(n);
    i_gms_host.rd(5'h0a, v);
    chk("count", v[7:0], n[7:0]);
    i_gms_host.rd(5'h0a, v);
    chk("count clr", v[7:0], 8'h00);
    errp(300);
    chk("sat", {sat, novf[7:0]}, 9'h101);
    i_gms_host.rd(5'h0a, v);
    chk("sat val", v[7:0], 8'hff);
    errp(5);
    lrst = 1;
    cyc(1);
    lrst = 0;
    i_gms_host.rd(5'h0a, v);
    chk("logic rst", v[7:0], 8'h00);
    i_gms_host.wr(5'h09, 16'h0000);
    errp(3);
    srst = 1;
    cyc(1);
    srst = 0;
    cyc(3);
    i_gms_host.rd(5'h0a, v);
    chk("soft rst", v[7:0], 8'h00);
    i_gms_host.rd(5'h09, v);
    chk("ctrl reload", v, {3'h0, strap, 8'h00});
    pge = 1;
    cyc(1);
    pge = 0;
    chk("page out", prx, 1'h1);
    i_gms_host.rd(5'h06, v);
    chk("page", v[1], 1'h1);
    i_gms_host.rd(5'h06, v);
    chk("page clr", v[1], 1'h0);
    chk("page out clr", prx, 1'h0);
    final_report;
  end
endmodule // testbench
bind gms_regs gms_regs_props i_gms_regs_props (
  .i_mclk(i_mclk),
  .i_nrst(i_nrst),
  .i_soft_rst(i_soft_rst),
  .i_logic_rst(i_logic_rst),
  .i_reg_idx(i_reg_idx),
  .i_rd_stb(i_rd_stb),
  .i_wr_stb(i_wr_stb),
  .i_wr_data(i_wr_data),
  .o_rd_data(o_rd_data),
  .i_page_rx_evt(i_page_rx_evt),
  .i_idle_err(i_idle_err),
  .o_test_mode(o_test_mode),
  .o_manual_cfg_en(o_manual_cfg_en),
  .o_manual_master(o_manual_master),
  .o_multiport(o_multiport),
  .o_adv_gig_fd(o_adv_gig_fd),
  .o_idle_cnt_sat(o_idle_cnt_sat),
  .o_page_rx(o_page_rx)
);
`default_nettype wire
